// file: verilog/spimsp_top.sv
// Serial port with AXI4-Lite registers, master or slave, full duplex byte transfers
`timescale 1ns/1ps
`include "spimsp_map.svh"
module spimsp_top (
    // Clock, reset and enable
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic ce,
    // AXI4-Lite write address
    input wire logic [4:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    // AXI4-Lite write data
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    // AXI4-Lite write response
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // AXI4-Lite read address
    input wire logic [4:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    // AXI4-Lite read data
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // Bit clock sources from on-chip logic, same clock domain
    input wire logic time_base_clock,
    input wire logic timer_period_match,
    // Serial pins
    input wire spimsp_pkg::spimsp_pin_in_s pin_in,
    output spimsp_pkg::spimsp_pin_out_s pin_out,
    // Interrupt
    output logic irq
);
    import spimsp_pkg::*;

    // Register state
    // The data byte doubles as the shift register, so there is no separate buffer
    logic [7:0] data_q; // Serial data byte, also the shift register
    logic [7:0] ctrl_a_q; // Role select and enable
    logic [7:0] ctrl_b_q; // Clock shape, order, select enable, flags
    logic [1:0] int_stat_q; // Sticky interrupt events
    logic [1:0] int_mask_q; // Interrupt enables
    // Bus channel state, each half of a write parked until its partner arrives
    logic aw_held_q; // Write address waiting
    logic [4:0] aw_addr_q; // Parked write address
    logic w_held_q;
    logic [31:0] w_data_q;
    logic [3:0] w_strb_q;
    // Transfer engine state
    // A master byte runs while busy; a slave byte while the edge count is nonzero
    logic busy_q; // Master transfer running
    logic [4:0] edge_cnt_q; // Clock edges done in this byte
    logic [5:0] div_q; // Half period counter
    logic sck_q; // Master clock level, true while away from idle
    logic sdo_q; // Bit being presented
    logic tbc_prev_q; // Time base level last cycle
    // Pin synchronisers
    logic [2:0] sck_sync_q; // [0] first stage, [1] second, [2] edge history
    logic [1:0] sdi_sync_q;
    logic [1:0] ss_sync_q;

    // Control field decode
    // Fields are read straight from the registers every cycle
    // Changing them during a byte corrupts that byte; software waits for done
    wire [2:0] role = ctrl_a_q[`SPIMSP_A_ROLE_HI:`SPIMSP_A_ROLE_LO];
    wire enabled = ctrl_a_q[`SPIMSP_A_EN];
    wire idle_low = ctrl_b_q[`SPIMSP_B_IDLE_LOW];
    wire cap_leading = ctrl_b_q[`SPIMSP_B_EDGE]; // Edge bit 0 catches on trailing edge either polarity
    wire lsb_first = ctrl_b_q[`SPIMSP_B_ORDER];
    wire sel_en = ctrl_b_q[`SPIMSP_B_SEL_EN];
    wire is_slave = role == SPIMSP_SLAVE;
    wire is_master = role < SPIMSP_SLAVE;
    wire reserved = role > SPIMSP_SLAVE;

    // Bus handshake decode
    // A write lands in the cycle both halves are parked and no response is pending
    // Only byte lane 0 carries register bits; other lanes are ignored
    wire aw_take = s_axi_awvalid & s_axi_awready;
    wire w_take = s_axi_wvalid & s_axi_wready;
    wire ar_take = s_axi_arvalid & s_axi_arready;
    wire wr_go = aw_held_q & w_held_q & ~s_axi_bvalid;
    wire wr_lane0 = w_strb_q[0];
    wire wr_data = wr_go & wr_lane0 & (aw_addr_q == `SPIMSP_OFF_DATA);
    wire wr_ctrl_a = wr_go & wr_lane0 & (aw_addr_q == `SPIMSP_OFF_CTRL_A);
    wire wr_ctrl_b = wr_go & wr_lane0 & (aw_addr_q == `SPIMSP_OFF_CTRL_B);
    wire wr_stat = wr_go & wr_lane0 & (aw_addr_q == `SPIMSP_OFF_INT_STAT);
    wire wr_mask = wr_go & wr_lane0 & (aw_addr_q == `SPIMSP_OFF_INT_MASK);
    wire wr_known = wr_data | wr_ctrl_a | wr_ctrl_b | wr_stat | wr_mask | ~wr_lane0;

    // Slave select and slave clock edges from synchronised pins
    // Pin edges reach the engine three cycles late, which bounds the slave clock rate
    // With select enable off the slave treats itself as always selected
    wire ss_active = ~sel_en | ~ss_sync_q[1];
    wire slave_run = enabled & is_slave & ss_active;
    wire pin_edge = sck_sync_q[1] ^ sck_sync_q[2];
    // Master half period ticks per source
    // The divider counts system clocks; the other two sources give one tick per half period
    // Reserved codes fall to the slowest divider but never start a transfer
    wire tbc_edge = time_base_clock ^ tbc_prev_q;
    logic [5:0] half_lim;
    always_comb begin
        unique case (role)
            SPIMSP_M_DIV4: half_lim = `SPIMSP_HALF_DIV4;
            SPIMSP_M_DIV16: half_lim = `SPIMSP_HALF_DIV16;
            default: half_lim = `SPIMSP_HALF_DIV64;
        endcase
    end
    wire div_tick = div_q == half_lim;
    wire src_tick = (role == SPIMSP_M_TBC) ? tbc_edge :
                    (role == SPIMSP_M_MATCH) ? timer_period_match : div_tick;
    wire master_edge = enabled & is_master & busy_q & src_tick;
    wire slave_edge = slave_run & pin_edge;
    wire any_edge = master_edge | slave_edge;
    wire leading = ~edge_cnt_q[0]; // Even edges leave idle, odd edges return
    wire capture = any_edge & (leading == cap_leading);
    wire launch = any_edge & (leading != cap_leading);
    wire last_edge = any_edge & (edge_cnt_q == `SPIMSP_EDGES - 5'h01);
    wire in_bit = is_slave ? sdi_sync_q[1] : sdi_sync_q[1];
    wire [7:0] shifted = lsb_first ? {in_bit, data_q[7:1]} : {data_q[6:0], in_bit};
    wire head = lsb_first ? data_q[0] : data_q[7];
    wire in_flight = busy_q | (edge_cnt_q != 5'h00);
    wire collide = wr_data & in_flight;
    wire start = wr_data & ~in_flight & enabled & is_master;

    // Readback mux, unused bits zero
    // The address is decoded combinationally and the byte is registered on the answer
    // Unmapped addresses read zero and answer with an error code
    logic [7:0] rd_byte;
    logic rd_ok;
    always_comb begin
        rd_ok = 1'b1;
        unique case (s_axi_araddr)
            `SPIMSP_OFF_DATA: rd_byte = data_q;
            `SPIMSP_OFF_CTRL_A: rd_byte = {ctrl_a_q[7:5], 3'h0, ctrl_a_q[1], 1'b0};
            `SPIMSP_OFF_CTRL_B: rd_byte = {2'h0, ctrl_b_q[5:0]};
            `SPIMSP_OFF_INT_STAT: rd_byte = {6'h00, int_stat_q};
            `SPIMSP_OFF_INT_MASK: rd_byte = {6'h00, int_mask_q};
            default: begin
                // Unmapped address
                rd_byte = 8'h00;
                rd_ok = 1'b0;
            end
        endcase
    end

    // Pin drive, all released while disabled
    // Clock level is formed from the idle-away state and the polarity bit
    // The select line is driven only by a master with select enable set
    spimsp_pin_out_s pins_d;
    always_comb begin
        pins_d.sck_o = sck_q ^ ~idle_low;
        pins_d.sck_oe = enabled & is_master;
        pins_d.sdo_o = sdo_q;
        pins_d.sdo_oe = enabled & (is_master | slave_run);
        pins_d.ss_n_o = ~busy_q;
        pins_d.ss_n_oe = enabled & is_master & sel_en;
    end

    // Input synchronisers, two stages before use
    // Select resets high so a released select line never looks active
    // The third clock stage only keeps history for the edge detector
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            sck_sync_q <= 3'h0;
            sdi_sync_q <= 2'h0;
            ss_sync_q <= 2'h3;
        end else if (ce) begin
            sck_sync_q <= {sck_sync_q[1:0], pin_in.sck};
            sdi_sync_q <= {sdi_sync_q[0], pin_in.sdi};
            ss_sync_q <= {ss_sync_q[0], pin_in.ss_n};
        end
    end

    // Write address and data channels, taken in either order
    // Each half is accepted once and held until the register write fires
    // No new half is accepted while the response waits for the master
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_held_q <= 1'b0;
            w_held_q <= 1'b0;
            aw_addr_q <= 5'h00;
            w_data_q <= 32'h0;
            w_strb_q <= 4'h0;
        end else if (ce) begin
            if (aw_take) begin
                aw_held_q <= 1'b1;
                aw_addr_q <= s_axi_awaddr;
            end else if (wr_go) begin
                aw_held_q <= 1'b0;
            end
            if (w_take) begin
                w_held_q <= 1'b1;
                w_data_q <= s_axi_wdata;
                w_strb_q <= s_axi_wstrb;
            end else if (wr_go) begin
                w_held_q <= 1'b0;
            end
        end
    end

    // Bus handshake outputs
    // Ready is registered and stays low after each take until that response has been taken
    // Responses stand until the master signals it has taken them
    // Only one read and one write can be in flight at a time
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_awready <= 1'b0;
            s_axi_wready <= 1'b0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= 2'h0;
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0;
            s_axi_rresp <= 2'h0;
        end else if (ce) begin
            s_axi_awready <= ~aw_held_q & ~aw_take & ~s_axi_bvalid;
            s_axi_wready <= ~w_held_q & ~w_take & ~s_axi_bvalid;
            // Response once both halves are in
            if (wr_go) begin
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= wr_known ? 2'h0 : 2'h2;
            end else if (s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
            s_axi_arready <= ~ar_take & ~s_axi_rvalid;
            // Read data one cycle after the address
            if (ar_take) begin
                s_axi_rvalid <= 1'b1;
                s_axi_rdata <= {24'h0, rd_byte};
                s_axi_rresp <= rd_ok ? 2'h0 : 2'h2;
            end else if (s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end

    // Control registers and sticky flags, a set beats a clear
    // Unused control bits are forced to zero on every write
    // Flags written through the control register clear on zero, status bits on one
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ctrl_a_q <= `SPIMSP_A_RESET;
            ctrl_b_q <= `SPIMSP_B_RESET;
            int_stat_q <= 2'h0;
            int_mask_q <= 2'h0;
        end else if (ce) begin
            if (wr_ctrl_a) begin
                ctrl_a_q <= {w_data_q[7:5], 3'h0, w_data_q[1], 1'b0};
            end
            if (wr_ctrl_b) begin
                ctrl_b_q[5:2] <= w_data_q[5:2];
            end
            ctrl_b_q[`SPIMSP_B_WCOL] <= collide | (wr_ctrl_b ? w_data_q[1] : ctrl_b_q[1]);
            ctrl_b_q[`SPIMSP_B_DONE] <= last_edge | (wr_ctrl_b ? w_data_q[0] : ctrl_b_q[0]);
            int_stat_q[`SPIMSP_I_DONE] <= last_edge | (int_stat_q[0] & ~(wr_stat & w_data_q[0]));
            int_stat_q[`SPIMSP_I_WCOL] <= collide | (int_stat_q[1] & ~(wr_stat & w_data_q[1]));
            if (wr_mask) begin
                int_mask_q <= w_data_q[1:0];
            end
        end
    end

    // Master clock generation and bit clock sources
    // Leaving master role or disabling the port abandons any byte in progress
    // The divider restarts at the start so the first half period is full length
    // The clock returns to its idle level after the sixteenth edge
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            busy_q <= 1'b0;
            div_q <= 6'h00;
            sck_q <= 1'b0;
            tbc_prev_q <= 1'b0;
        end else if (ce) begin
            tbc_prev_q <= time_base_clock;
            if (!enabled || !is_master || reserved) begin
                busy_q <= 1'b0;
                sck_q <= 1'b0;
                div_q <= 6'h00;
            end else if (start) begin
                busy_q <= 1'b1;
                div_q <= 6'h00;
            end else if (busy_q) begin
                div_q <= div_tick ? 6'h00 : div_q + 6'h01;
                if (master_edge) begin
                    sck_q <= ~sck_q;
                end
                if (last_edge) begin
                    busy_q <= 1'b0;
                end
            end
        end
    end

    // Shift engine: data register shifts in place, both directions at once
    // A data write during a byte is refused and only raises the collision flag
    // Captured bits enter at the end opposite the outgoing bit
    // The edge count tracks both master and slave bytes
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            data_q <= 8'h00;
            edge_cnt_q <= 5'h00;
            sdo_q <= 1'b0;
        end else if (ce) begin
            if (wr_data && !in_flight) begin
                data_q <= w_data_q[7:0];
            end else if (capture) begin
                data_q <= shifted;
            end
            // Deselect or disable drops a partial byte
            if (!enabled || (is_slave && !ss_active)) begin
                edge_cnt_q <= 5'h00;
            end else if (last_edge) begin
                edge_cnt_q <= 5'h00;
            end else if (any_edge) begin
                edge_cnt_q <= edge_cnt_q + 5'h01;
            end
            // Present first bit while idle, next bit at each launch edge
            // A fresh byte shows its first bit at once, so a leading capture edge sees it
            if (wr_data && !in_flight) begin
                sdo_q <= lsb_first ? w_data_q[0] : w_data_q[7];
            end else if (!in_flight || launch) begin
                sdo_q <= head;
            end
        end
    end

    // Pin and interrupt output registers
    // Every top output comes from a flop, so pins and interrupt lag their cause by one cycle
    // The interrupt is a level that follows the masked status bits
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            pin_out <= '0;
            irq <= 1'b0;
        end else if (ce) begin
            pin_out <= pins_d;
            irq <= |(int_stat_q & int_mask_q);
        end
    end
endmodule : spimsp_top

// file: verilog/spimsp_map.svh
// Register map, field positions, reset values and clock divider counts of the serial port
`ifndef SPIMSP_MAP_SVH
`define SPIMSP_MAP_SVH
// Byte offsets on the register bus
`define SPIMSP_OFF_DATA 5'h00
`define SPIMSP_OFF_CTRL_A 5'h04
`define SPIMSP_OFF_CTRL_B 5'h08
`define SPIMSP_OFF_INT_STAT 5'h0C
`define SPIMSP_OFF_INT_MASK 5'h10
// Control a fields
`define SPIMSP_A_ROLE_HI 7
`define SPIMSP_A_ROLE_LO 5
`define SPIMSP_A_EN 1
`define SPIMSP_A_RESET 8'hE0
// Control b fields
`define SPIMSP_B_IDLE_LOW 5
`define SPIMSP_B_EDGE 4
`define SPIMSP_B_ORDER 3
`define SPIMSP_B_SEL_EN 2
`define SPIMSP_B_WCOL 1
`define SPIMSP_B_DONE 0
`define SPIMSP_B_RESET 8'h00
// Interrupt bit positions (status and mask)
`define SPIMSP_I_DONE 0
`define SPIMSP_I_WCOL 1
// Divider terminal counts, one less than the half serial clock period in system clocks
`define SPIMSP_HALF_DIV4 6'h01
`define SPIMSP_HALF_DIV16 6'h07
`define SPIMSP_HALF_DIV64 6'h1F
// Clock edges in one byte transfer
`define SPIMSP_EDGES 5'h10
`endif

// file: verilog/spimsp_pkg.sv
// Types shared by the serial port design
package spimsp_pkg;
    // Role and bit clock source codes
    typedef enum logic [2:0] {
        SPIMSP_M_DIV4 = 3'b000,
        SPIMSP_M_DIV16 = 3'b001,
        SPIMSP_M_DIV64 = 3'b010,
        SPIMSP_M_TBC = 3'b011,
        SPIMSP_M_MATCH = 3'b100,
        SPIMSP_SLAVE = 3'b101,
        SPIMSP_RSV6 = 3'b110,
        SPIMSP_RSV7 = 3'b111
    } spimsp_role_e;
    // Pin levels coming in
    typedef struct packed {
        logic sck;
        logic sdi;
        logic ss_n;
    } spimsp_pin_in_s;
    // Pin drive going out, enable high while driving
    typedef struct packed {
        logic sck_o;
        logic sck_oe;
        logic sdo_o;
        logic sdo_oe;
        logic ss_n_o;
        logic ss_n_oe;
    } spimsp_pin_out_s;
endpackage : spimsp_pkg

// file: verif/spimsp_chk.sv
// Assertions on the serial port top ports
`timescale 1ns/1ps
module spimsp_chk (
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // Bus handshakes
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [1:0] s_axi_bresp,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic [31:0] s_axi_rdata,
    // Pins and interrupt
    input wire spimsp_pkg::spimsp_pin_out_s pin_out,
    input wire logic irq
);
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    // Write answer two cycles after both halves are taken
    wr_resp_a: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##2 s_axi_bvalid)
        else $error("write response not on time");
    // Read answer one cycle after the address is taken
    rd_resp_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read response not on time");
    // Responses stand until taken
    b_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write response dropped early");
    r_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read data dropped early");
    // No new request accepted while an answer is pending
    ar_block_a: assert property (s_axi_rvalid |-> !s_axi_arready)
        else $error("read address taken during answer");
    w_block_a: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
        else $error("write taken during answer");
    // Fastest serial clock holds each level two cycles
    sck_pace_a: assert property ($changed(pin_out.sck_o) && pin_out.sck_oe && $past(pin_out.sck_oe)
        |=> $stable(pin_out.sck_o))
        else $error("serial clock half period too short");
    // Reset leaves every pin released, the interrupt low and the write answer idle
    rst_quiet_a: assert property (disable iff (1'b0) !aresetn |=> pin_out == '0 && !irq && !s_axi_bvalid)
        else $error("outputs active after reset");
    // Main activity seen
    cover property (s_axi_bvalid && s_axi_bready);
    cover property (s_axi_rvalid && s_axi_rready);
    cover property ($changed(pin_out.sck_o) && pin_out.sck_oe);
endmodule : spimsp_chk
bind spimsp_top spimsp_chk u_spimsp_chk (.aclk(aclk), .aresetn(aresetn), .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_bresp(s_axi_bresp),
    .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready), .s_axi_rdata(s_axi_rdata), .pin_out(pin_out), .irq(irq));

// file: verif/spimsp_slave_model.sv
// Behavioural external peripheral on the far side of the serial link
`timescale 1ns/1ps
module spimsp_slave_model (
    // Serial wires
    input wire logic sck,
    input wire logic sdo,
    output logic sdi,
    // Setup from the bench
    input wire logic cap_rise,
    input wire logic lsb_first,
    input wire logic load,
    input wire logic [7:0] tx_byte,
    output logic [7:0] rx_byte
);
    logic [7:0] tx_q = 8'h00; // Byte to return
    logic [3:0] idx = 4'h8; // Bits captured, 8 means idle
    initial rx_byte = 8'h00;
    // Arm a new byte
    always @(posedge load) begin
        tx_q = tx_byte;
        idx = 4'h0;
    end
    // Capture one bit on the chosen edge, eight per byte
    always @(sck) begin
        if (sck === cap_rise && idx < 4'h8) begin
            rx_byte = lsb_first ? {sdo, rx_byte[7:1]} : {rx_byte[6:0], sdo};
            idx = idx + 4'h1;
        end
    end
    // Next bit right after each capture; when done, the inverse of the last bit
    assign sdi = (idx < 4'h8) ? tx_q[lsb_first ? idx[2:0] : 3'h7 - idx[2:0]] : ~tx_q[lsb_first ? 7 : 0];
endmodule : spimsp_slave_model

// file: verif/tb_spi_master_slave_port.sv
// Self-checking bench: register access and master transfers of the serial port
`timescale 1ns/1ps
`include "spimsp_map.svh"
module tb_spi_master_slave_port;
    import spimsp_pkg::*;
    logic aclk = 1'b0;
    logic aresetn = 1'b0;
    logic [4:0] awaddr = 5'h00, araddr = 5'h00;
    logic [31:0] wdata = 32'h0, rd, rdata;
    logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
    logic awready, wready, bvalid, arready, rvalid, irq, sdi, sck_prev = 0;
    logic [1:0] bresp, rresp, pace = 2'h0, ss;
    logic tbc = 0, match = 0, m_load = 0, m_cap = 0, m_lsb = 0;
    logic [7:0] m_tx = 8'h00, m_rx;
    spimsp_pin_in_s pin_in;
    spimsp_pin_out_s pin_out;
    int mismatches = 0, check_count = 0, tog = 0, cyc = 0;
    int c_at [0:255];
    // Pin levels: select line pulled up when released
    assign pin_in = {pin_out.sck_o, sdi, pin_out.ss_n_oe ? pin_out.ss_n_o : 1'b1};
    always #25 aclk = ~aclk;
    spimsp_top u_spimsp_top (.aclk(aclk), .aresetn(aresetn), .ce(1'b1), .s_axi_awaddr(awaddr),
        .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF),
        .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
        .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
        .time_base_clock(tbc), .timer_period_match(match), .pin_in(pin_in), .pin_out(pin_out), .irq(irq));
    spimsp_slave_model u_spimsp_slave_model (.sck(pin_out.sck_o), .sdo(pin_out.sdo_o), .sdi(sdi),
        .cap_rise(m_cap), .lsb_first(m_lsb), .load(m_load), .tx_byte(m_tx), .rx_byte(m_rx));
    // On-chip bit clock sources: a change and a pulse every third cycle
    always @(posedge aclk) begin
        pace <= (pace == 2'h2) ? 2'h0 : pace + 2'h1;
        tbc <= tbc ^ (pace == 2'h2);
        match <= (pace == 2'h2);
    end
    // Note the cycle of every serial clock change
    always @(posedge aclk) begin
        cyc <= cyc + 1;
        sck_prev <= pin_out.sck_o;
        if (pin_out.sck_oe && pin_out.sck_o !== sck_prev) begin
            c_at[tog[7:0]] <= cyc;
            tog <= tog + 1;
        end
    end
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            mismatches++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check
    task automatic finish_test;
        $display("checks=%0d mismatches=%0d", check_count, mismatches);
        if (mismatches == 0 && check_count > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask : finish_test
    // Bus write: both halves offered together, each released when taken
    task automatic axi_write(input logic [4:0] a, input logic [31:0] d);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do begin
            @(posedge aclk);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
        end while (!bvalid);
        bready <= 1'b0;
        @(posedge aclk);
    endtask : axi_write
    // Bus read: hold the address until taken, data at the answer edge
    task automatic axi_read(input logic [4:0] a, output logic [31:0] d);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do @(posedge aclk); while (!arready);
        arvalid <= 1'b0;
        while (!rvalid) @(posedge aclk);
        d = rdata;
        rready <= 1'b0;
        @(posedge aclk);
    endtask : axi_read
    // One master byte; cfg is idle_low, edge, lsb first, select enable
    task automatic xfer(input logic [2:0] code, input logic [3:0] cfg, input int half,
        input logic [7:0] tx, input logic [7:0] back, input logic col);
        int t0;
        axi_write(`SPIMSP_OFF_CTRL_B, {26'h0, cfg, 2'b00});
        axi_write(`SPIMSP_OFF_CTRL_A, {24'h0, code, 5'b00010});
        m_tx <= back;
        m_cap <= (cfg[3] == cfg[2]);
        m_lsb <= cfg[1];
        @(posedge aclk);
        m_load <= 1'b1;
        @(posedge aclk);
        m_load <= 1'b0;
        t0 = tog;
        axi_write(`SPIMSP_OFF_DATA, {24'h0, tx});
        ss = {pin_out.ss_n_oe, pin_out.ss_n_o};
        if (col) axi_write(`SPIMSP_OFF_DATA, 32'h0);
        do axi_read(`SPIMSP_OFF_CTRL_B, rd); while (rd[0] !== 1'b1);
        check(rd[1], col);
        check(tog - t0, 16);
        check(c_at[t0 + 15] - c_at[t0], 15 * half);
        check(pin_out.sck_o, !cfg[3]);
        check(ss[1], cfg[0]);
        if (cfg[0]) check(ss[0], 1'b0);
        check(m_rx, tx);
        axi_read(`SPIMSP_OFF_DATA, rd);
        check(rd, back);
    endtask : xfer
    // Main sequence
    initial begin
        repeat (12) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        check({pin_out.sck_oe, pin_out.sdo_oe, pin_out.ss_n_oe}, 3'b000);
        axi_read(`SPIMSP_OFF_CTRL_A, rd);
        check(rd, 32'hE0);
        axi_read(`SPIMSP_OFF_CTRL_B, rd);
        check(rd, 32'h00);
        axi_read(5'h02, rd);
        check(rd, 32'h0);
        axi_write(`SPIMSP_OFF_CTRL_A, 32'hBF);
        axi_read(`SPIMSP_OFF_CTRL_A, rd);
        check(rd, 32'hA2);
        xfer(3'b000, 4'b0001, 2, 8'hA5, 8'h3C, 1'b0);
        xfer(3'b001, 4'b0110, 8, 8'h81, 8'h7E, 1'b0);
        xfer(3'b010, 4'b1011, 32, 8'hC3, 8'h5A, 1'b1);
        axi_write(`SPIMSP_OFF_INT_MASK, 32'h3);
        check(irq, 1'b1);
        axi_read(`SPIMSP_OFF_INT_MASK, rd);
        check(rd, 32'h3);
        axi_read(`SPIMSP_OFF_INT_STAT, rd);
        check(rd[1:0], 2'b11);
        axi_write(`SPIMSP_OFF_INT_STAT, 32'h3);
        check(irq, 1'b0);
        axi_read(`SPIMSP_OFF_INT_STAT, rd);
        check(rd[1:0], 2'b00);
        xfer(3'b011, 4'b1100, 3, 8'h0F, 8'hF1, 1'b0);
        xfer(3'b100, 4'b0011, 3, 8'h96, 8'h69, 1'b0);
        axi_write(`SPIMSP_OFF_CTRL_A, 32'h0);
        repeat (3) @(posedge aclk);
        check({pin_out.sck_oe, pin_out.sdo_oe, pin_out.ss_n_oe}, 3'b000);
        finish_test;
    end
    // Watchdog: the whole run needs about a thousand cycles
    initial begin
        repeat (20000) @(posedge aclk);
        mismatches++;
        finish_test;
    end
endmodule : tb_spi_master_slave_port
